// >>> src/ssr_pkg.sv
package ssr_pkg;
   // ==========================================================
   // Status summary byte layout
   localparam int STB_QUES_BIT = 3;
   localparam int STB_MAV_BIT  = 4;
   localparam int STB_ESB_BIT  = 5;
   localparam int STB_RQS_BIT  = 6;
   localparam logic [7:0] STB_USED_MASK = 8'h78;

   // ==========================================================
   // Standard event layout: bits 0,2,3,4,5,7 implemented
   localparam logic [7:0]  ESR_USED_MASK  = 8'hBD;
   // Questionable layout: bits 0,1,9,11,12 implemented
   localparam logic [15:0] QUES_USED_MASK = 16'h1A03;

   // ==========================================================
   // Register select codes on the command port
   typedef enum logic [2:0] {
      SSR_SEL_STB,
      SSR_SEL_SRE,
      SSR_SEL_ESR,
      SSR_SEL_ESE,
      SSR_SEL_QEVT,
      SSR_SEL_QENB
   } ssr_sel_t;

   // Command strobes from the command parser, one-cycle pulses
   typedef struct packed {
      logic clear_status;   // Clear status command
      logic status_preset;  // Status preset command
      logic reset_cmd;      // Reset command, no status effect
      logic device_clear;   // Bus device clear, no status effect
      logic serial_poll;    // Bus serial poll
      logic power_on;       // Power-on event, applies clear setting
   } ssr_cmd_t;

   // Readings path events
   typedef struct packed {
      logic direct_mode;    // 1: readings go directly to output
      logic first_trigger;  // First reading trigger pulse
      logic all_done;       // All measurements completed pulse
      logic out_nonempty;   // Output buffer holds data
   } ssr_rdg_t;
endpackage

// >>> src/ssr_status.sv
// ==========================================================
module ssr_status (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              clk_en,
   input  wire ssr_pkg::ssr_cmd_t cmd,
   input  wire ssr_pkg::ssr_rdg_t rdg,
   input  wire logic              cmds_idle,
   input  wire logic              psc_setting,
   input  wire logic [7:0]        std_event_in,
   input  wire logic [15:0]       ques_event_in,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire ssr_pkg::ssr_sel_t reg_sel,
   input  wire logic [15:0]       reg_wdata,
   output logic [15:0]            reg_rdata,
   output logic                   reg_rvalid,
   output logic [7:0]             poll_byte,
   output logic                   poll_valid,
   output logic                   srq_out
);
   // ==========================================================
   // State
   logic [7:0]  esr_r,  esr_nxt;
   logic [7:0]  ese_r,  ese_nxt;
   logic [15:0] ques_r, ques_nxt;
   logic [15:0] qenb_r, qenb_nxt;
   logic [7:0]  sre_r,  sre_nxt;
   logic        mav_r,  mav_nxt;
   logic        held_r, held_nxt;   // Reading available flag
   logic        nonempty_r;         // Buffer held data last cycle
   logic        rqs_r,  rqs_nxt;
   logic        esb_r,  qsb_r;
   logic        stbq_pend_r;

   // ==========================================================
   // Access decode
   wire wr_sre  = reg_wr && reg_sel == ssr_pkg::SSR_SEL_SRE;
   wire wr_ese  = reg_wr && reg_sel == ssr_pkg::SSR_SEL_ESE;
   wire wr_qenb = reg_wr && reg_sel == ssr_pkg::SSR_SEL_QENB;
   wire rd_esr  = reg_rd && reg_sel == ssr_pkg::SSR_SEL_ESR;
   wire rd_ques = reg_rd && reg_sel == ssr_pkg::SSR_SEL_QEVT;
   wire rd_stb  = reg_rd && reg_sel == ssr_pkg::SSR_SEL_STB;
   wire rd_plain = reg_rd && !rd_stb;

   // ==========================================================
   // Event latches: set wins over any clear in the same cycle
   wire [7:0]  esr_set  = std_event_in & ssr_pkg::ESR_USED_MASK;
   wire [15:0] ques_set = ques_event_in & ssr_pkg::QUES_USED_MASK;
   wire esr_clr  = cmd.clear_status || rd_esr;
   wire ques_clr = cmd.clear_status || rd_ques;
   // Reset command and device clear are deliberately not decoded
   assign esr_nxt  = (esr_clr ? 8'h00 : esr_r) | esr_set;
   assign ques_nxt = (ques_clr ? 16'h0000 : ques_r) | ques_set;

   // ==========================================================
   // Enable masks
   assign ese_nxt  = wr_ese ? reg_wdata[7:0] : ese_r;
   // Preset wins over a write arriving in the same cycle
   assign qenb_nxt = cmd.status_preset ? 16'h0000
                   : wr_qenb ? reg_wdata : qenb_r;
   // Power-on clears only if the stored setting asks for it
   assign sre_nxt  = (cmd.power_on && psc_setting) ? 8'h00
                   : wr_sre ? (reg_wdata[7:0] & ssr_pkg::STB_USED_MASK)
                   : sre_r;

   // ==========================================================
   // Message available
   // Stored mode holds off until every measurement has finished
   wire rdg_evt = rdg.direct_mode ? rdg.first_trigger
                                  : rdg.all_done;
   // Flag drops only once the buffer drains, so a trigger that comes
   // before its reading reaches the buffer still reports data pending
   wire buf_drained = nonempty_r && !rdg.out_nonempty;
   assign held_nxt = rdg_evt ? 1'b1
                   : (buf_drained ? 1'b0 : held_r);
   assign mav_nxt  = rdg.out_nonempty || rdg_evt || held_r;

   // ==========================================================
   // Summaries are recomputed every cycle, never latched
   wire esb_nxt = |(esr_nxt & ese_nxt);
   wire qsb_nxt = |(ques_nxt & qenb_nxt);

   // Summary positions of the status byte, next and present
   logic [7:0] sum_nxt;
   logic [7:0] sum_cur;
   always_comb begin
      sum_nxt = 8'h00;
      sum_nxt[ssr_pkg::STB_QUES_BIT] = qsb_nxt;
      sum_nxt[ssr_pkg::STB_MAV_BIT]  = mav_nxt;
      sum_nxt[ssr_pkg::STB_ESB_BIT]  = esb_nxt;
      sum_cur = 8'h00;
      sum_cur[ssr_pkg::STB_QUES_BIT] = qsb_r;
      sum_cur[ssr_pkg::STB_MAV_BIT]  = mav_r;
      sum_cur[ssr_pkg::STB_ESB_BIT]  = esb_r;
   end

   // Request service: rises on an enabled summary becoming true
   wire req_any   = |(sum_nxt & sre_nxt);
   wire req_cur   = |(sum_cur & sre_r);
   wire req_rise  = req_any && !req_cur;
   // Reading the causing register drops the cause, so rqs follows
   wire src_read  = (rd_esr && esb_r) || (rd_ques && qsb_r);
   assign rqs_nxt = req_rise ? 1'b1
                  : (cmd.serial_poll || cmd.clear_status ||
                     (src_read && !req_any)) ? 1'b0
                  : rqs_r;

   // Status byte as seen this cycle; bits 0-2 and 7 stay zero
   logic [7:0] stb_now;
   always_comb begin
      stb_now = sum_cur;
      stb_now[ssr_pkg::STB_RQS_BIT] = rqs_r;
   end

   // ==========================================================
   // Read data mux; values are the binary-weighted contents
   logic [15:0] rd_mux;
   always_comb begin
      case (reg_sel)
         ssr_pkg::SSR_SEL_STB:  rd_mux = {8'h00, stb_now};
         ssr_pkg::SSR_SEL_SRE:  rd_mux = {8'h00, sre_r};
         ssr_pkg::SSR_SEL_ESR:  rd_mux = {8'h00, esr_r};
         ssr_pkg::SSR_SEL_ESE:  rd_mux = {8'h00, ese_r};
         ssr_pkg::SSR_SEL_QEVT: rd_mux = ques_r;
         ssr_pkg::SSR_SEL_QENB: rd_mux = qenb_r;
         default:               rd_mux = 16'h0000;
      endcase
   end

   // Status byte query is held until the parser reports idle
   wire stbq_go = (rd_stb || stbq_pend_r) && cmds_idle;

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         esr_r <= 8'h00;
         ques_r <= 16'h0000;
         ese_r <= 8'h00;
         qenb_r <= 16'h0000;
         sre_r <= 8'h00;
         mav_r <= 1'b0;
         held_r <= 1'b0;
         nonempty_r <= 1'b0;
         rqs_r <= 1'b0;
         esb_r <= 1'b0;
         qsb_r <= 1'b0;
      end else if (clk_en) begin
         esr_r <= esr_nxt;
         ques_r <= ques_nxt;
         ese_r <= ese_nxt;
         qenb_r <= qenb_nxt;
         sre_r <= sre_nxt;
         mav_r <= mav_nxt;
         held_r <= held_nxt;
         nonempty_r <= rdg.out_nonempty;
         rqs_r <= rqs_nxt;
         esb_r <= esb_nxt;
         qsb_r <= qsb_nxt;
      end
   end

   // Answers; poll answers at once, status byte query changes nothing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
         poll_byte <= 8'h00;
         poll_valid <= 1'b0;
         srq_out <= 1'b0;
         stbq_pend_r <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid <= rd_plain || stbq_go;
         reg_rdata <= stbq_go ? {8'h00, stb_now} : rd_mux;
         stbq_pend_r <= (rd_stb || stbq_pend_r) && !cmds_idle;
         poll_valid <= cmd.serial_poll;
         poll_byte <= stb_now;
         srq_out <= rqs_nxt;
      end
   end

   // ==========================================================
   // Checks
   // Standard event bits never fall without a clear
   a_event_latch_hold: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && !esr_clr)
      |=> ((esr_r & $past(esr_r)) == $past(esr_r)))
      else $error("event bit lost without clear");
   // Questionable bits never fall without a clear
   a_ques_latch_hold: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && !ques_clr)
      |=> ((ques_r & $past(ques_r)) == $past(ques_r)))
      else $error("questionable bit lost without clear");
   // Clear status empties the standard event latch
   a_clear_status_clr: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && cmd.clear_status && esr_set == 8'h00)
      |=> esr_r == 8'h00)
      else $error("clear status left event bits");
   // Clear status empties the questionable latch
   a_cls_clr_ques: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && cmd.clear_status && ques_set == 16'h0000)
      |=> ques_r == 16'h0000)
      else $error("clear status left questionable bits");
   // Query of the standard event latch empties it
   a_query_clr_esr: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && rd_esr && esr_set == 8'h00)
      |=> esr_r == 8'h00)
      else $error("event query left bits set");
   // Query of the questionable latch empties it
   a_query_clr_ques: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && rd_ques && ques_set == 16'h0000)
      |=> ques_r == 16'h0000)
      else $error("questionable query left bits set");
   // Reset command and device clear leave the latch alone
   a_reset_cmd_keep: assert property (@(posedge clk_sys)
      disable iff (reset)
      (clk_en && (cmd.reset_cmd || cmd.device_clear) && !esr_clr)
      |=> esr_r == ($past(esr_r) | $past(esr_set)))
      else $error("reset command touched event bits");
   // Read data is the latch contents as they stood
   a_rdata_weights: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && rd_esr && !stbq_pend_r)
      |=> reg_rdata == {8'h00, $past(esr_r)})
      else $error("event query returned wrong value");
   // Standard summary tracks the enabled event bits
   a_summary_follow: assert property (@(posedge clk_sys)
      disable iff (reset) clk_en
      |=> esb_r == |(esr_r & ese_r))
      else $error("summary not tracking events");
   // Questionable summary tracks the enabled bits
   a_qsum_follow: assert property (@(posedge clk_sys)
      disable iff (reset) clk_en
      |=> qsb_r == |(ques_r & qenb_r))
      else $error("questionable summary not tracking");
   // Clear status spares the enable mask
   a_mask_keep_cls: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && cmd.clear_status && !wr_ese)
      |=> $stable(ese_r))
      else $error("clear status changed enable mask");
   // Reading any register leaves the enable mask as it was
   a_mask_keep_read: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && reg_rd && !wr_ese)
      |=> $stable(ese_r))
      else $error("read changed enable mask");
   // Status preset zeroes the questionable mask
   a_preset_qenb: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && cmd.status_preset)
      |=> qenb_r == 16'h0000)
      else $error("preset did not clear mask");
   // Data in the buffer always shows as message available
   a_mav_follows_buf: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && rdg.out_nonempty)
      |=> mav_r)
      else $error("buffer data not reported");
   // Unused status byte positions read zero
   a_stb_unused_zero: assert property (@(posedge clk_sys)
      disable iff (reset) (stb_now & ~ssr_pkg::STB_USED_MASK) == 8'h00)
      else $error("unused status byte bit set");
   // Power-on with the clear setting empties the mask
   a_power_on_sre: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && cmd.power_on && psc_setting)
      |=> sre_r == 8'h00)
      else $error("power-on clear setting ignored");
   // Writing zero to the summary mask clears it
   a_sre_write_zero: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && wr_sre && reg_wdata[7:0] == 8'h00)
      |=> sre_r == 8'h00)
      else $error("zero write left summary mask set");
   // A new request always has an enabled summary behind it
   a_rqs_has_source: assert property (@(posedge clk_sys)
      disable iff (reset) $rose(rqs_r)
      |-> |(sum_cur & sre_r))
      else $error("request without enabled source");
   // Service request line is the request bit itself
   a_srq_follows_rqs: assert property (@(posedge clk_sys)
      disable iff (reset) srq_out == rqs_r)
      else $error("service request out of step");
   // Request bit falls only on a poll, a clear status or a read of its source
   a_rqs_holds: assert property (@(posedge clk_sys)
      disable iff (reset)
      (clk_en && rqs_r && !cmd.serial_poll && !cmd.clear_status && !src_read)
      |=> rqs_r)
      else $error("request bit dropped without cause");
   // Serial poll answers and drops the request bit
   a_poll_clears_rqs: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && cmd.serial_poll && !req_rise)
      |=> !rqs_r ##0 poll_valid)
      else $error("poll did not clear request");
   // Poll returns the status byte as it stood at the poll
   a_poll_value: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && cmd.serial_poll)
      |=> poll_byte == $past(stb_now))
      else $error("poll returned wrong status byte");
   // Status byte query leaves the request bit set
   a_stbq_keeps_rqs: assert property (@(posedge clk_sys)
      disable iff (reset)
      (clk_en && rd_stb && rqs_r && !cmd.serial_poll && !cmd.clear_status)
      |=> rqs_r)
      else $error("status byte query cleared request");
   // A held status byte query is not answered while busy
   a_stbq_waits: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && stbq_pend_r && !cmds_idle && !reg_rd)
      |=> !reg_rvalid)
      else $error("status byte query answered early");
   // Direct readings report data at the first trigger
   a_direct_mav_set: assert property (@(posedge clk_sys)
      disable iff (reset) (clk_en && rdg.direct_mode && rdg.first_trigger)
      |=> mav_r)
      else $error("first trigger not reported");
   // Stored readings: nothing to report until all are done
   a_stored_mav_wait: assert property (@(posedge clk_sys)
      disable iff (reset)
      (clk_en && !rdg.direct_mode && !rdg.all_done && !rdg.out_nonempty
       && !held_r) |=> !mav_r)
      else $error("message available before completion");
   // Standard event bits 1 and 6 never set
   a_esr_layout: assert property (@(posedge clk_sys)
      disable iff (reset) (esr_r & ~ssr_pkg::ESR_USED_MASK) == 8'h00)
      else $error("unused standard event bit set");
   // Only the five questionable bits can set
   a_ques_layout: assert property (@(posedge clk_sys)
      disable iff (reset) (ques_r & ~ssr_pkg::QUES_USED_MASK) == 16'h0000)
      else $error("unused questionable bit set");
   // Clock enable low freezes every register and output
   a_freeze_hold: assert property (@(posedge clk_sys)
      disable iff (reset) !clk_en
      |=> $stable(esr_r) && $stable(ques_r) && $stable(rqs_r)
          && $stable(srq_out) && $stable(reg_rvalid))
      else $error("state moved while clock enable low");
endmodule

// >>> test/ssr_host.sv
// ==========================================================
// Bus controller model: one request per task, entered at a
// falling edge so every strobe lands well clear of the clock
module ssr_host (
   input  wire logic        clk_sys,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid,
   input  wire logic [7:0]  poll_byte,
   input  wire logic        poll_valid,
   output ssr_pkg::ssr_sel_t reg_sel,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [15:0]      reg_wdata,
   output ssr_pkg::ssr_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial begin
      reg_sel = ssr_pkg::SSR_SEL_STB;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'hA5A5;
      cmd = '0;
   end

   // Write pulse; released data shows the inverse, never stale data
   task automatic wr(input ssr_pkg::ssr_sel_t s, input logic [15:0] v);
      reg_sel = s;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_wdata = ~v;
   endtask

   // Query pulse; bounded wait since the status byte may be held back
   task automatic rd(input ssr_pkg::ssr_sel_t s, output logic [15:0] v);
      int n;
      reg_sel = s;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      v = reg_rdata;
   endtask

   // One-cycle command strobe, as the parser would issue it
   task automatic pulse(input logic [5:0] c);
      cmd = ssr_pkg::ssr_cmd_t'(c);
      @(negedge clk_sys);
      cmd = '0;
   endtask

   // Serial poll: answered by the bus side at once
   task automatic poll(output logic [7:0] b);
      int n;
      pulse(6'h02);
      n = 0;
      while (poll_valid !== 1'b1 && n < 8) begin
         @(negedge clk_sys);
         n++;
      end
      b = poll_byte;
   endtask
endmodule

// >>> test/ssr_status_tb.sv
module ssr_status_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk_sys = 1'b0;
   logic              reset = 1'b1;
   logic              cmds_idle = 1'b1;
   logic              psc_setting = 1'b0;
   logic              clk_en = 1'b1;
   logic [7:0]        std_ev = '0;
   logic [15:0]       ques_ev = '0;
   ssr_pkg::ssr_rdg_t rdg = '0;
   ssr_pkg::ssr_sel_t reg_sel;
   ssr_pkg::ssr_cmd_t cmd;
   logic              reg_wr, reg_rd, reg_rvalid, poll_valid, srq_out;
   logic [15:0]       reg_wdata, reg_rdata, d;
   logic [7:0]        poll_byte, pb;
   int                n_mismatch = 0;
   int                num_checks = 0;
   int                cycles = 0;

   // ==========================================================
   // Clock, design and controller
   always #50 clk_sys = ~clk_sys;
   ssr_status ssr_status_i (.clk_sys(clk_sys), .reset(reset),
      .clk_en(clk_en), .cmd(cmd), .rdg(rdg), .cmds_idle(cmds_idle),
      .psc_setting(psc_setting), .std_event_in(std_ev),
      .ques_event_in(ques_ev), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .poll_byte(poll_byte),
      .poll_valid(poll_valid), .srq_out(srq_out));
   ssr_host ssr_host_i (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .poll_byte(poll_byte),
      .poll_valid(poll_valid), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .cmd(cmd));

   // ==========================================================
   // Checking helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rc(input ssr_pkg::ssr_sel_t s, input logic [15:0] e);
      ssr_host_i.rd(s, d);
      chk(d, e);
   endtask
   // Event pulses, then time for the summaries to settle
   task automatic ev(input logic [7:0] s, input logic [15:0] q);
      std_ev = s;
      ques_ev = q;
      @(negedge clk_sys);
      std_ev = '0;
      ques_ev = '0;
      repeat (2) @(negedge clk_sys);
   endtask
   // Readings path pulse; direct_mode and out_nonempty are kept
   task automatic rp(input logic [3:0] v);
      rdg = v;
      @(negedge clk_sys);
      rdg = v & 4'h9;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Hang guard, far above the hundred or so cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(negedge clk_sys);
      reset = 1'b0;
      rc(ssr_pkg::SSR_SEL_STB, 16'h0000);
      ev(8'hFF, 16'hFFFF);
      ssr_host_i.pulse(6'h0C);
      rc(ssr_pkg::SSR_SEL_ESR, 16'h00BD);
      rc(ssr_pkg::SSR_SEL_QEVT, 16'h1A03);
      rc(ssr_pkg::SSR_SEL_ESR, 16'h0000);
      // Controller set-up before relying on requests
      ssr_host_i.pulse(6'h04);
      ssr_host_i.pulse(6'h20);
      ssr_host_i.wr(ssr_pkg::SSR_SEL_ESE, 16'h0001);
      ssr_host_i.wr(ssr_pkg::SSR_SEL_SRE, 16'h0020);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0000);
      ev(8'h01, 16'h0000);
      chk({15'h0, srq_out}, 16'h0001);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0060);
      chk({15'h0, srq_out}, 16'h0001);
      ssr_host_i.poll(pb);
      chk({8'h0, pb}, 16'h0060);
      chk({15'h0, srq_out}, 16'h0000);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0020);
      rc(ssr_pkg::SSR_SEL_ESR, 16'h0001);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0000);
      // Mask refuses unused bits; clear-status spares the masks
      ssr_host_i.wr(ssr_pkg::SSR_SEL_SRE, 16'h00FF);
      rc(ssr_pkg::SSR_SEL_SRE, 16'h0078);
      ev(8'h01, 16'h0000);
      ssr_host_i.pulse(6'h20);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0000);
      rc(ssr_pkg::SSR_SEL_ESR, 16'h0000);
      rc(ssr_pkg::SSR_SEL_ESE, 16'h0001);
      rc(ssr_pkg::SSR_SEL_SRE, 16'h0078);
      // Questionable source read drops the request
      ssr_host_i.wr(ssr_pkg::SSR_SEL_QENB, 16'h0201);
      rc(ssr_pkg::SSR_SEL_QENB, 16'h0201);
      ev(8'h00, 16'h0200);
      chk({15'h0, srq_out}, 16'h0001);
      rc(ssr_pkg::SSR_SEL_QEVT, 16'h0200);
      chk({15'h0, srq_out}, 16'h0000);
      ssr_host_i.pulse(6'h10);
      rc(ssr_pkg::SSR_SEL_QENB, 16'h0000);
      ev(8'h00, 16'h0200);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0000);
      // Power-on clear setting
      ssr_host_i.pulse(6'h01);
      rc(ssr_pkg::SSR_SEL_SRE, 16'h0078);
      psc_setting = 1'b1;
      ssr_host_i.pulse(6'h01);
      rc(ssr_pkg::SSR_SEL_SRE, 16'h0000);
      // Message available, direct then stored readings
      rp(4'hC);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0010);
      rp(4'h9);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0010);
      rp(4'h0);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0000);
      rp(4'h4);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0000);
      rp(4'h2);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0010);
      rp(4'h1);
      rp(4'h0);
      rc(ssr_pkg::SSR_SEL_STB, 16'h0000);
      // Clock enable low: a write and an event are both lost
      clk_en = 1'b0;
      ssr_host_i.wr(ssr_pkg::SSR_SEL_ESE, 16'h0000);
      ev(8'h01, 16'h0000);
      clk_en = 1'b1;
      rc(ssr_pkg::SSR_SEL_ESE, 16'h0001);
      rc(ssr_pkg::SSR_SEL_ESR, 16'h0000);
      // Status byte query held until earlier commands finish
      cmds_idle = 1'b0;
      fork
         ssr_host_i.rd(ssr_pkg::SSR_SEL_STB, d);
         begin
            repeat (4) @(negedge clk_sys);
            chk({15'h0, reg_rvalid}, 16'h0000);
            cmds_idle = 1'b1;
         end
      join
      chk(d, 16'h0000);
      results();
   end
endmodule
